// [hdl/umcls_pkg.sv]
package umcls_pkg;

    // ==========================================================
    // Clock and bit timing
    localparam int CLK_HZ = 50_000_000;
    localparam int BAUD_HZ = 115_200;
    localparam int BIT_CYC = CLK_HZ / BAUD_HZ;
    localparam int CNT_W = 9;
    localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYC - 1);
    localparam int DATA_BITS = 8;
    localparam logic [2:0] DATA_LAST = 3'(DATA_BITS - 1);

    // ==========================================================
    // Register map (byte addresses)
    localparam int ADR_W = 8;
    localparam logic [ADR_W-1:0] OFF_TX_DATA = 8'h00;
    localparam logic [ADR_W-1:0] OFF_FIFO_CTL = 8'h08;
    localparam logic [ADR_W-1:0] OFF_MODEM_CTL = 8'h10;
    localparam logic [ADR_W-1:0] OFF_LINE_STAT = 8'h14;
    localparam logic [ADR_W-1:0] OFF_IRQ_STAT = 8'h18;
    localparam logic [ADR_W-1:0] OFF_IRQ_EN = 8'h1C;
    localparam logic [ADR_W-1:0] OFF_IRQ_CLR = 8'h20;

    // ==========================================================
    // Field layouts and reset values
    localparam int MCTL_DTR = 0;
    localparam int MCTL_RTS = 1;
    localparam int MCTL_FLOW = 5;
    localparam logic [7:0] MCTL_WMASK = 8'h3F;
    localparam logic [7:0] MCTL_RST = 8'h00;
    localparam int FIFO_CTL_EN = 0;
    localparam int LSTAT_HOLD_EMPTY = 5;
    localparam int LSTAT_TX_EMPTY = 6;
    localparam int LSTAT_ERR_SUM = 7;
    localparam int IRQ_N = 2;
    localparam int IRQ_FERR = 0;
    localparam int IRQ_TEMT = 1;
    localparam logic [IRQ_N-1:0] IRQ_RST = 2'h0;

    // ==========================================================
    // Transmit shifter states, Gray coded along the frame
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_START = 2'b01,
        TX_DATA = 2'b11,
        TX_STOP = 2'b10
    } umcls_tx_state_t;

endpackage

// [hdl/umcls_flow.sv]
`timescale 1ns/1ns
module umcls_flow (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic [7:0] modem_ctl,
    input wire logic rx_above_trig,
    // Handshake pins and decoded modes
    output logic rts_n,
    output logic dtr_n,
    output logic auto_rts_en,
    output logic auto_cts_en
);

    // ==========================================================
    // Mode decode
    wire flow_en = modem_ctl[umcls_pkg::MCTL_FLOW];
    wire rts_bit = modem_ctl[umcls_pkg::MCTL_RTS];
    wire auto_rts_nxt = flow_en & rts_bit;
    wire auto_cts_nxt = flow_en;
    // In auto mode the receiver stops the far end once it holds too much.
    wire rts_n_nxt = auto_rts_nxt ? rx_above_trig : ~rts_bit;
    wire dtr_n_nxt = ~modem_ctl[umcls_pkg::MCTL_DTR];

    // ==========================================================
    // Pin registers
    always_ff @(posedge clk) begin
        if (rst) begin
            rts_n <= 1'b1;
            dtr_n <= 1'b1;
            auto_rts_en <= 1'b0;
            auto_cts_en <= 1'b0;
        end else begin
            rts_n <= rts_n_nxt;
            dtr_n <= dtr_n_nxt;
            auto_rts_en <= auto_rts_nxt;
            auto_cts_en <= auto_cts_nxt;
        end
    end

endmodule

// [hdl/umcls_txsh.sv]
`timescale 1ns/1ns
module umcls_txsh (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Character source
    input wire logic load_valid,
    input wire logic [7:0] load_data,
    input wire logic start_ok,
    output logic load_take,
    // Status and line
    output logic busy,
    output logic tx_out
);

    // ==========================================================
    // Frame sequencer
    umcls_pkg::umcls_tx_state_t state_r, state_nxt;
    logic [umcls_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic out_nxt;

    wire bit_end = (cnt_r == umcls_pkg::BIT_LAST);
    // A character is only started while start_ok is high; the top ties that to the far end only in auto CTS mode.
    assign load_take = (state_r == umcls_pkg::TX_IDLE) & load_valid & start_ok;
    assign busy = (state_r != umcls_pkg::TX_IDLE);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = bit_end ? '0 : cnt_r + 1'b1;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        out_nxt = tx_out;
        case (state_r)
            umcls_pkg::TX_IDLE: begin
                cnt_nxt = '0;
                out_nxt = 1'b1;
                if (load_take) begin
                    sh_nxt = load_data;
                    out_nxt = 1'b0;
                    state_nxt = umcls_pkg::TX_START;
                end
            end
            umcls_pkg::TX_START: begin
                if (bit_end) begin
                    out_nxt = sh_r[0];
                    bit_nxt = '0;
                    state_nxt = umcls_pkg::TX_DATA;
                end
            end
            umcls_pkg::TX_DATA: begin
                if (bit_end) begin
                    if (bit_r == umcls_pkg::DATA_LAST) begin
                        out_nxt = 1'b1;
                        state_nxt = umcls_pkg::TX_STOP;
                    end else begin
                        sh_nxt = {1'b0, sh_r[7:1]};
                        out_nxt = sh_r[1];
                        bit_nxt = bit_r + 1'b1;
                    end
                end
            end
            umcls_pkg::TX_STOP: begin
                if (bit_end) begin
                    state_nxt = umcls_pkg::TX_IDLE;
                end
            end
            default: begin
                state_nxt = umcls_pkg::TX_IDLE;
                out_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= umcls_pkg::TX_IDLE;
            cnt_r <= '0;
            bit_r <= '0;
            sh_r <= 8'h00;
            tx_out <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            tx_out <= out_nxt;
        end
    end

endmodule

// [hdl/umcls_top.sv]
`timescale 1ns/1ns
module umcls_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Modem handshake
    input wire logic cts_n,
    output logic rts_n,
    output logic dtr_n,
    // Serial line
    output logic tx_out,
    // Receive FIFO side
    input wire logic rx_push,
    input wire logic rx_push_err,
    input wire logic rx_above_trig,
    // Transmit FIFO side
    input wire logic tx_fifo_empty,
    input wire logic [7:0] tx_fifo_data,
    output logic tx_fifo_push,
    output logic [7:0] tx_fifo_wdata,
    output logic tx_fifo_pop,
    // Interrupt
    output logic irq
);

    // ==========================================================
    // Address decode
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr == off);
    endfunction

    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr = req & wb_we_i & wb_sel_i[0];
    wire rd = req & ~wb_we_i;
    wire hit_tx = hit(wb_adr_i, umcls_pkg::OFF_TX_DATA);
    wire hit_fctl = hit(wb_adr_i, umcls_pkg::OFF_FIFO_CTL);
    wire hit_mctl = hit(wb_adr_i, umcls_pkg::OFF_MODEM_CTL);
    wire hit_lstat = hit(wb_adr_i, umcls_pkg::OFF_LINE_STAT);
    wire hit_ist = hit(wb_adr_i, umcls_pkg::OFF_IRQ_STAT);
    wire hit_ien = hit(wb_adr_i, umcls_pkg::OFF_IRQ_EN);
    wire hit_icl = hit(wb_adr_i, umcls_pkg::OFF_IRQ_CLR);
    wire [7:0] wbyte = wb_dat_i[7:0];

    // ==========================================================
    // Control and status state
    logic [7:0] mctl_r;
    logic fifo_en_r;
    logic [7:0] hold_r;
    logic hold_full_r;
    logic ferr_r;
    logic temt_prev_r;
    logic [umcls_pkg::IRQ_N-1:0] irq_stat_r;
    logic [umcls_pkg::IRQ_N-1:0] irq_en_r;
    logic auto_cts_en;
    logic tx_take;
    logic tx_busy;

    // ==========================================================
    // Handshake pins and flow mode
    umcls_flow u_flow (
        .clk(clk),
        .rst(rst),
        .modem_ctl(mctl_r),
        .rx_above_trig(rx_above_trig),
        .rts_n(rts_n),
        .dtr_n(dtr_n),
        .auto_rts_en(),
        .auto_cts_en(auto_cts_en)
    );

    // ==========================================================
    // Transmit path
    // The shifter loads from the holding register, or from the FIFO in FIFO mode.
    wire src_valid = fifo_en_r ? ~tx_fifo_empty : hold_full_r;
    wire [7:0] src_data = fifo_en_r ? tx_fifo_data : hold_r;
    wire start_ok = ~auto_cts_en | ~cts_n;

    umcls_txsh u_txsh (
        .clk(clk),
        .rst(rst),
        .load_valid(src_valid),
        .load_data(src_data),
        .start_ok(start_ok),
        .load_take(tx_take),
        .busy(tx_busy),
        .tx_out(tx_out)
    );

    wire tx_wr = wr & hit_tx;
    wire hold_full_nxt = (~fifo_en_r & tx_wr) | (hold_full_r & ~(tx_take & ~fifo_en_r));
    wire [7:0] hold_nxt = (~fifo_en_r & tx_wr) ? wbyte : hold_r;
    // The transmitter is empty only when no character waits anywhere.
    wire store_empty = fifo_en_r ? tx_fifo_empty : ~hold_full_r;
    wire temt = store_empty & ~tx_busy;
    wire thre = store_empty;

    // ==========================================================
    // Line status
    wire lstat_rd = rd & hit_lstat;
    // A new error arriving in the same cycle as the read survives it.
    wire ferr_nxt = (rx_push & rx_push_err) | (ferr_r & ~lstat_rd);
    wire [7:0] lstat_val = {ferr_r, temt, thre, 5'h00};

    // ==========================================================
    // Interrupt status, set wins over clear
    wire [umcls_pkg::IRQ_N-1:0] ev;
    wire [umcls_pkg::IRQ_N-1:0] clr = (wr & hit_icl) ? wbyte[umcls_pkg::IRQ_N-1:0] : '0;
    wire [umcls_pkg::IRQ_N-1:0] irq_stat_nxt;
    assign ev[umcls_pkg::IRQ_FERR] = rx_push & rx_push_err;
    assign ev[umcls_pkg::IRQ_TEMT] = temt & ~temt_prev_r;

    genvar gi;
    generate
        for (gi = 0; gi < umcls_pkg::IRQ_N; gi = gi + 1) begin : g_irq
            assign irq_stat_nxt[gi] = ev[gi] | (irq_stat_r[gi] & ~clr[gi]);
        end
    endgenerate

    wire irq_nxt = |(irq_stat_nxt & irq_en_r);

    // ==========================================================
    // Register writes
    wire [7:0] mctl_nxt = (wr & hit_mctl) ? (wbyte & umcls_pkg::MCTL_WMASK) : mctl_r;
    wire fifo_en_nxt = (wr & hit_fctl) ? wbyte[umcls_pkg::FIFO_CTL_EN] : fifo_en_r;
    wire [umcls_pkg::IRQ_N-1:0] irq_en_nxt =
        (wr & hit_ien) ? wbyte[umcls_pkg::IRQ_N-1:0] : irq_en_r;

    // ==========================================================
    // Read data
    wire [7:0] rd_byte =
        hit_mctl ? mctl_r :
        hit_lstat ? lstat_val :
        hit_fctl ? {7'h00, fifo_en_r} :
        hit_ist ? {6'h00, irq_stat_r} :
        hit_ien ? {6'h00, irq_en_r} : 8'h00;
    wire [31:0] dat_nxt = rd ? {24'h000000, rd_byte} : 32'h00000000;

    // ==========================================================
    // Flip-flops
    always_ff @(posedge clk) begin
        if (rst) begin
            mctl_r <= umcls_pkg::MCTL_RST;
            fifo_en_r <= 1'b0;
            hold_r <= 8'h00;
            hold_full_r <= 1'b0;
            ferr_r <= 1'b0;
            temt_prev_r <= 1'b1;
            irq_stat_r <= umcls_pkg::IRQ_RST;
            irq_en_r <= umcls_pkg::IRQ_RST;
            irq <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            mctl_r <= mctl_nxt;
            fifo_en_r <= fifo_en_nxt;
            hold_r <= hold_nxt;
            hold_full_r <= hold_full_nxt;
            ferr_r <= ferr_nxt;
            temt_prev_r <= temt;
            irq_stat_r <= irq_stat_nxt;
            irq_en_r <= irq_en_nxt;
            irq <= irq_nxt;
            wb_ack_o <= req;
            wb_dat_o <= dat_nxt;
        end
    end

    // ==========================================================
    // Transmit FIFO strobes
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_fifo_push <= 1'b0;
            tx_fifo_wdata <= 8'h00;
            tx_fifo_pop <= 1'b0;
        end else begin
            tx_fifo_push <= fifo_en_r & tx_wr;
            tx_fifo_wdata <= tx_wr ? wbyte : tx_fifo_wdata;
            tx_fifo_pop <= fifo_en_r & tx_take;
        end
    end

endmodule

// [testbench/umcls_properties.sv]
`timescale 1ns/1ns
// ==========================================================
// Port checker for the modem control and line status block
module umcls_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Pins and receive side
    input wire logic cts_n,
    input wire logic rts_n,
    input wire logic dtr_n,
    input wire logic tx_out,
    input wire logic rx_push,
    input wire logic rx_push_err,
    input wire logic rx_above_trig
);
    // Pins are judged only once a control write has had time to reach them.
    logic [7:0] mctl_r;
    logic [1:0] age_r;
    logic [12:0] fcnt_r;
    logic err_r;
    logic txq_r;
    wire acc = wb_cyc_i & wb_stb_i & wb_ack_o;
    wire mctl_wr = acc & wb_we_i & wb_sel_i[0] & (wb_adr_i == umcls_pkg::OFF_MODEM_CTL);
    wire lstat_rd = acc & !wb_we_i & (wb_adr_i == umcls_pkg::OFF_LINE_STAT);
    // The flag model clears on the edge that takes the read, as the block does.
    wire lstat_take = wb_cyc_i & wb_stb_i & !wb_ack_o & !wb_we_i
        & (wb_adr_i == umcls_pkg::OFF_LINE_STAT);
    wire settled = (age_r == 2'h3);
    wire auto_cts = settled & mctl_r[5];
    wire auto_rts = auto_cts & mctl_r[1];
    wire start = txq_r & !tx_out & (fcnt_r == 13'h0);
    always_ff @(posedge clk) begin
        txq_r <= tx_out;
        mctl_r <= rst ? 8'h00 : mctl_wr ? (wb_dat_i[7:0] & umcls_pkg::MCTL_WMASK) : mctl_r;
        age_r <= rst ? 2'h3 : mctl_wr ? 2'h0 : settled ? 2'h3 : age_r + 2'h1;
        fcnt_r <= rst ? 13'h0 : start ? 13'(10 * umcls_pkg::BIT_CYC - 1)
            : fcnt_r - 13'(fcnt_r != 13'h0);
        err_r <= !rst & ((rx_push & rx_push_err) | (err_r & !lstat_take));
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    property p_dtr;
        settled |-> dtr_n == !mctl_r[0];
    endproperty
    a_dtr: assert property (p_dtr) else $error("ready pin wrong");
    property p_rts_sw;
        settled && !auto_rts |-> rts_n == !mctl_r[1];
    endproperty
    a_rts_sw: assert property (p_rts_sw) else $error("request pin wrong");
    property p_rts_auto;
        (auto_rts && $stable(rx_above_trig))[*3] |-> rts_n == rx_above_trig;
    endproperty
    a_rts_auto: assert property (p_rts_auto) else $error("auto request wrong");
    property p_cts;
        (auto_cts && cts_n)[*4] |-> !start;
    endproperty
    a_cts: assert property (p_cts) else $error("start while held");
    property p_err;
        lstat_rd |-> wb_dat_o[7] == $past(err_r);
    endproperty
    a_err: assert property (p_err) else $error("error summary wrong");
    property p_temt;
        lstat_rd && fcnt_r > 13'h1 |-> !wb_dat_o[6];
    endproperty
    a_temt: assert property (p_temt) else $error("empty while sending");
    property p_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack timing wrong");
    property p_dat;
        !wb_ack_o |-> wb_dat_o == 32'h0;
    endproperty
    a_dat: assert property (p_dat) else $error("read data outside ack");
    c_auto_rts: cover property (auto_rts && !rts_n);
    c_err: cover property (lstat_rd && wb_dat_o[7]);
    c_start: cover property (start && auto_cts);
endmodule

bind umcls_top umcls_chk i_chk (
    .clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .cts_n, .rts_n, .dtr_n, .tx_out, .rx_push, .rx_push_err,
    .rx_above_trig
);

// [testbench/umcls_modem.sv]
`timescale 1ns/1ns
// ==========================================================
// Modem model: grants clear-to-send and decodes the serial line
module umcls_modem (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Handshake and line
    input wire logic hold,
    input wire logic dtr_n,
    input wire logic tx_out,
    output logic cts_n,
    output logic [7:0] rx_byte,
    output logic [7:0] rx_count
);
    localparam int B = umcls_pkg::BIT_CYC;
    logic [12:0] t_r;
    logic [7:0] sh_r;
    // A peripheral never grants the line to a terminal that is not ready.
    always_ff @(posedge clk) begin
        cts_n <= rst | hold | dtr_n;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            t_r <= 13'h0;
            rx_count <= 8'h00;
        end else if (t_r == 13'h0) begin
            t_r <= {12'h0, !tx_out};
        end else if (t_r == 13'(19 * B / 2)) begin
            t_r <= 13'h0;
            rx_byte <= sh_r;
            rx_count <= rx_count + 8'h01;
        end else begin
            t_r <= t_r + 13'h1;
            if (t_r % B == B / 2) sh_r <= {tx_out, sh_r[7:1]};
        end
    end
endmodule

// [testbench/umcls_top_tb.sv]
`timescale 1ns/1ns
`define CHK(g, e) check_val(32'(g), 32'(e))
// ==========================================================
// Self-checking bench for the modem control and line status block
module umcls_top_tb;
    localparam int B = umcls_pkg::BIT_CYC;
    localparam logic [7:0] LINE = umcls_pkg::OFF_LINE_STAT;
    localparam logic [7:0] MODEM = umcls_pkg::OFF_MODEM_CTL;
    localparam logic [7:0] TXD = umcls_pkg::OFF_TX_DATA;
    logic clk, rst, cyc, stb, we, ack, cts_n, rts_n, dtr_n, tx_out, irq, hold;
    logic push, perr, trig, fempty, fpush, fpop;
    logic [7:0] adr, fdata, fwdata, rx_byte, rx_count, d, pushed;
    logic [31:0] wdat, rdat, q, seed;
    logic [7:0] mctl_tbl [6] = '{8'h00, 8'h03, 8'h23, 8'h22, 8'h21, 8'h20};
    int mismatches, total_checks;
    umcls_top i_dut (
        .clk, .rst, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .cts_n,
        .rts_n, .dtr_n, .tx_out, .rx_push(push), .rx_push_err(perr), .rx_above_trig(trig),
        .tx_fifo_empty(fempty), .tx_fifo_data(fdata), .tx_fifo_push(fpush),
        .tx_fifo_wdata(fwdata), .tx_fifo_pop(fpop), .irq
    );
    umcls_modem i_modem (.clk, .rst, .hold, .dtr_n, .tx_out, .cts_n, .rx_byte, .rx_count);
    function automatic logic exp_rts(logic [7:0] m, logic t);
        return (m[5] & m[1]) ? t : !m[1];
    endfunction
    task automatic check_val(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH at %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] v);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h0, v};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        {cyc, stb} <= 2'b00;
        if (n >= 50) mismatches++;
    endtask
    task automatic push_char(input logic e);
        @(posedge clk);
        {push, perr} <= {1'b1, e};
        @(posedge clk);
        push <= 1'b0;
    endtask
    task automatic wait_rx(input logic [7:0] n, input logic [7:0] v);
        for (int k = 0; k < 20000 && rx_count !== n; k++) @(posedge clk);
        `CHK(rx_count, n);
        `CHK(rx_byte, v);
        repeat (B) @(posedge clk);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) if (fpush === 1'b1) pushed <= fwdata;
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        complete_run();
    end
    initial begin
        {cyc, stb, we, push, perr, trig, hold, adr, fdata, wdat} = '0;
        {fempty, rst, mismatches, total_checks} = {2'b11, 64'h0};
        seed = $urandom(32'h48110AE0);
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // An unmapped write must leave no trace anywhere.
        wb(1'b1, 8'hFC, 8'hFF);
        wb(1'b0, 8'hFC, 8'h00);
        `CHK(q, 0);
        wb(1'b0, MODEM, 8'h00);
        `CHK({q, rts_n, dtr_n}, 2'b11);
        wb(1'b0, LINE, 8'h00);
        `CHK(q, 32'h60);
        $display("reset test done");
        for (int i = 0; i < 10; i++) begin
            d = (i < 6) ? mctl_tbl[i] : 8'($urandom);
            trig <= 1'($urandom);
            wb(1'b1, MODEM, d);
            repeat (4) @(posedge clk);
            wb(1'b0, MODEM, 8'h00);
            `CHK({q, dtr_n}, {d & 8'h3F, !d[0]});
            `CHK(rts_n, exp_rts(d, trig));
            trig <= !trig;
            repeat (4) @(posedge clk);
            `CHK(rts_n, exp_rts(d, trig));
        end
        $display("control test done");
        wb(1'b1, umcls_pkg::OFF_IRQ_EN, 8'h01);
        repeat (2 + $urandom % 4) push_char(1'b0);
        wb(1'b0, LINE, 8'h00);
        `CHK({q[7], irq}, 0);
        push_char(1'b1);
        push_char(1'b0);
        repeat (2) @(posedge clk);
        `CHK(irq, 1);
        wb(1'b0, LINE, 8'h00);
        `CHK(q[7], 1);
        wb(1'b0, LINE, 8'h00);
        `CHK(q[7], 0);
        for (int i = 0; i < 3; i++) begin
            wb(1'b1, (i == 2) ? umcls_pkg::OFF_IRQ_CLR : umcls_pkg::OFF_IRQ_EN, 8'(i != 0));
            repeat (3) @(posedge clk);
            `CHK(irq, i == 1);
        end
        $display("error test done");
        wb(1'b1, MODEM, 8'h01);
        hold <= 1'b1;
        d = 8'($urandom);
        wb(1'b1, TXD, d);
        wb(1'b0, LINE, 8'h00);
        `CHK(q[6], 0);
        wait_rx(8'h01, d);
        wb(1'b0, LINE, 8'h00);
        `CHK(q[6], 1);
        wb(1'b0, umcls_pkg::OFF_IRQ_STAT, 8'h00);
        `CHK(q[1], 1);
        wb(1'b1, MODEM, 8'h21);
        d = 8'($urandom);
        wb(1'b1, TXD, d);
        repeat (2 * B) @(posedge clk);
        wb(1'b0, LINE, 8'h00);
        `CHK({q[6], tx_out}, 2'b01);
        hold <= 1'b0;
        wait_rx(8'h02, d);
        $display("transmit test done");
        hold <= 1'b1;
        wb(1'b1, umcls_pkg::OFF_FIFO_CTL, 8'h01);
        d = 8'($urandom);
        fdata <= 8'($urandom);
        fempty <= 1'b0;
        wb(1'b1, TXD, d);
        repeat (2) @(posedge clk);
        `CHK(pushed, d);
        wb(1'b0, LINE, 8'h00);
        `CHK(q[6], 0);
        fempty <= 1'b1;
        wb(1'b0, LINE, 8'h00);
        `CHK(q[6], 1);
        {fempty, hold} <= 2'b00;
        for (int k = 0; k < 50 && fpop !== 1'b1; k++) @(posedge clk);
        fempty <= 1'b1;
        wait_rx(8'h03, fdata);
        $display("fifo test done");
        complete_run();
    end
endmodule
